// [common/lin_cmd_pkg.sv]
// Frame layout constants for the OTP write and sleep command decoder.
package lin_cmd_pkg;
  localparam logic [7:0] OTP_ID = 8'he7;
  localparam logic [7:0] SLEEP_ID = 8'h3c;
  localparam logic [7:0] FILL_BYTE = 8'hff;
  localparam logic [7:0] SLEEP_FIRST = 8'h00;
  localparam logic [1:0] ADDR_TOP = 2'h3;
  localparam logic [3:0] PTR_TOP = 4'hf;
  localparam int ADDR_MSB = 5;
  localparam int PTR_MSB = 3;
  localparam logic [3:0] OTP_LEN = 4'h4;
  localparam logic [3:0] SLEEP_LEN = 4'h8;
  localparam logic [3:0] IDX_B1 = 4'h1;
  localparam logic [3:0] IDX_B2 = 4'h2;
  localparam logic [3:0] IDX_B3 = 4'h3;
  localparam logic [3:0] IDX_B4 = 4'h4;
  typedef enum logic [1:0] {ST_IDLE, ST_DATA, ST_CHK} dec_state_e;
endpackage : lin_cmd_pkg

// [hw/lin_checksum.sv]
// Classic LIN checksum accumulator with carry wrap-around.
module lin_checksum (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic clear_i,
  input wire logic add_i,
  input wire logic [7:0] byte_i,
  output logic [7:0] sum_o
);
  logic [7:0] sum_q;
  logic [8:0] wide;

  assign wide = {1'b0, sum_q} + {1'b0, byte_i};

  always_ff @(posedge clk_i) begin
    if (!reset_n_i || clear_i) begin
      sum_q <= 8'h00;
    end else if (add_i) begin
      sum_q <= wide[7:0] + {7'h00, wide[8]};
    end
  end

  assign sum_o = sum_q;
endmodule // lin_checksum

// [hw/lin_otp_write_and_sleep_decoder.sv]
// Decoder for the OTP byte write frame and the sleep master request frame.
// How it works
// (R01) A valid OTP frame writes its fourth data byte into one OTP byte.
// (R02) The 4-bit pointer in data byte 3 selects the written OTP byte.
// (R03) OTP frame: id e7, byte1 11+address, byte2 ff, byte3 1111+pointer.
// (R04) Sleep frame: id 3c, first byte 00, seven more bytes ff.
// (R05) A valid sleep frame sends the device into sleep mode.
// (R06) The bus master issues the sleep frame to sleep all slaves.
// (R07) OTP frames with foreign address or bad checksum are ignored.
module lin_otp_write_and_sleep_decoder
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic frame_start_i,
  input wire logic [7:0] frame_id_i,
  input wire logic byte_valid_i,
  input wire logic [7:0] byte_i,
  input wire logic [lin_cmd_pkg::ADDR_MSB:0] node_addr_i,
  input wire logic wake_i,
  output logic otp_write_o,
  output logic [lin_cmd_pkg::PTR_MSB:0] otp_addr_o,
  output logic [7:0] otp_data_o,
  output logic sleep_o,
  output logic frame_error_o
);
  import lin_cmd_pkg::*;

  // Decoder state.
  dec_state_e state_q;
  logic is_sleep_q;
  logic match_q;
  logic [3:0] idx_q;
  logic [PTR_MSB:0] ptr_q;
  logic [7:0] data_q;

  // Header, field and byte decoding.
  logic [3:0] len;
  logic [7:0] sum;
  logic byte_ok;
  logic chk_ok;
  logic take;
  logic done;
  logic id_otp;
  logic id_sleep;
  logic id_known;
  logic [1:0] b1_top;
  logic [ADDR_MSB:0] b1_addr;
  logic [3:0] b3_top;
  logic [PTR_MSB:0] b3_ptr;
  logic otp_b1_ok;
  logic fill_ok;
  logic otp_b3_ok;
  logic sleep_b1_ok;
  logic last_data;
  logic sum_add;

  // Frame verdicts.
  logic frame_ok;
  logic otp_ok;
  logic sleep_ok;

  assign len = is_sleep_q ? SLEEP_LEN : OTP_LEN;
  assign take = byte_valid_i && (state_q != ST_IDLE);
  assign chk_ok = (byte_i == ~sum);
  assign done = byte_valid_i && (state_q == ST_CHK);

  // Header and field decoding.
  assign id_otp = (frame_id_i == OTP_ID); // R03
  assign id_sleep = (frame_id_i == SLEEP_ID); // R04
  assign id_known = id_otp || id_sleep;
  assign b1_top = byte_i[7:ADDR_MSB + 1];
  assign b1_addr = byte_i[ADDR_MSB:0];
  assign b3_top = byte_i[7:PTR_MSB + 1];
  assign b3_ptr = byte_i[PTR_MSB:0];
  assign otp_b1_ok = (b1_top == ADDR_TOP) && (b1_addr == node_addr_i); // R03 R07
  assign fill_ok = (byte_i == FILL_BYTE); // R03 R04
  assign otp_b3_ok = (b3_top == PTR_TOP); // R03
  assign sleep_b1_ok = (byte_i == SLEEP_FIRST); // R04
  assign last_data = (idx_q == len);
  assign sum_add = take && (state_q == ST_DATA);

  // Frame verdicts.
  assign frame_ok = done && match_q && chk_ok; // R07
  assign otp_ok = frame_ok && !is_sleep_q; // R01 R07
  assign sleep_ok = frame_ok && is_sleep_q; // R05

  lin_checksum u_sum (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .clear_i(frame_start_i),
    .add_i(sum_add),
    .byte_i(byte_i),
    .sum_o(sum)
  );

  // Checks each data byte against the expected frame pattern.
  always_comb begin
    byte_ok = 1'b1;
    if (is_sleep_q) begin
      byte_ok = (idx_q == IDX_B1) ? sleep_b1_ok : fill_ok; // R04
    end else begin
      case (idx_q)
        IDX_B1: byte_ok = otp_b1_ok; // R03 R07
        IDX_B2: byte_ok = fill_ok; // R03
        IDX_B3: byte_ok = otp_b3_ok; // R03
        default: byte_ok = 1'b1;
      endcase
    end
  end

  // Frame type, latched from the header.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      is_sleep_q <= 1'b0;
    end else if (frame_start_i) begin
      is_sleep_q <= id_sleep; // R04
    end
  end

  // Data byte index, restarted by every header.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      idx_q <= 4'h0;
    end else if (frame_start_i) begin
      idx_q <= IDX_B1;
    end else if (sum_add) begin
      idx_q <= idx_q + 4'h1;
    end
  end

  // Frame sequencing.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      state_q <= ST_IDLE;
    end else if (frame_start_i) begin
      state_q <= id_known ? ST_DATA : ST_IDLE; // R03 R04
    end else if (take) begin
      case (state_q)
        ST_DATA: begin
          if (last_data) begin
            state_q <= ST_CHK;
          end
        end
        ST_CHK: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Running pattern match over the data bytes.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      match_q <= 1'b0;
    end else if (frame_start_i) begin
      match_q <= 1'b1;
    end else if (sum_add) begin
      match_q <= match_q && byte_ok; // R03 R04 R07
    end
  end

  // OTP byte pointer from data byte 3.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      ptr_q <= '0;
    end else if (sum_add && !is_sleep_q && idx_q == IDX_B3) begin
      ptr_q <= b3_ptr; // R02
    end
  end

  // OTP byte content from data byte 4.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      data_q <= 8'h00;
    end else if (sum_add && !is_sleep_q && idx_q == IDX_B4) begin
      data_q <= byte_i; // R01
    end
  end

  // OTP write strobe, one cycle per valid OTP frame.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      otp_write_o <= 1'b0;
    end else begin
      otp_write_o <= otp_ok; // R01 R07
    end
  end

  // OTP address, held until the next accepted OTP frame.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      otp_addr_o <= '0;
    end else if (otp_ok) begin
      otp_addr_o <= ptr_q; // R02
    end
  end

  // OTP content, held until the next accepted OTP frame.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      otp_data_o <= 8'h00;
    end else if (otp_ok) begin
      otp_data_o <= data_q; // R01
    end
  end

  // Sleep mode level, left on wake.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      sleep_o <= 1'b0;
    end else if (sleep_ok) begin
      sleep_o <= 1'b1; // R05 R06
    end else if (wake_i) begin
      sleep_o <= 1'b0;
    end
  end

  // Pulses when a decoded frame is rejected.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      frame_error_o <= 1'b0;
    end else begin
      frame_error_o <= done && !frame_ok; // R07
    end
  end
endmodule // lin_otp_write_and_sleep_decoder

// [test/lin_dec_chk.sv]
// Assertions on the decoder ports.
module lin_dec_chk (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic byte_valid_i,
  input wire logic wake_i,
  input wire logic otp_write_o,
  input wire logic [lin_cmd_pkg::PTR_MSB:0] otp_addr_o,
  input wire logic sleep_o,
  input wire logic frame_error_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  property p_wr; otp_write_o |-> $past(byte_valid_i); endproperty
  a_wr: assert property (p_wr) else $error("stray write");
  property p_one; otp_write_o |=> !otp_write_o; endproperty
  a_one: assert property (p_one) else $error("long write");
  property p_ad; !otp_write_o |-> $stable(otp_addr_o); endproperty
  a_ad: assert property (p_ad) else $error("addr moved");
  property p_ex; !(otp_write_o && frame_error_o); endproperty
  a_ex: assert property (p_ex) else $error("write on error");
  property p_sl; $rose(sleep_o) |-> $past(byte_valid_i); endproperty
  a_sl: assert property (p_sl) else $error("stray sleep");
  property p_wk; $fell(sleep_o) |-> $past(wake_i); endproperty
  a_wk: assert property (p_wk) else $error("stray wake");
  c_wr: cover property (otp_write_o);
  c_er: cover property (frame_error_o);
  c_sl: cover property (sleep_o);
endmodule // lin_dec_chk
bind lin_otp_write_and_sleep_decoder lin_dec_chk chk_u (
  .clk_i(clk_i),
  .reset_n_i(reset_n_i),
  .byte_valid_i(byte_valid_i),
  .wake_i(wake_i),
  .otp_write_o(otp_write_o),
  .otp_addr_o(otp_addr_o),
  .sleep_o(sleep_o),
  .frame_error_o(frame_error_o)
);

// [test/lin_master_model.sv]
// Bus master model that sends command frames to the decoder.
module lin_master_model (
  input wire logic clk_i,
  output logic frame_start_o = 1'b0,
  output logic [7:0] frame_id_o = 8'h00,
  output logic byte_valid_o = 1'b0,
  output logic [7:0] byte_o = 8'h00
);
  timeunit 1ns;
  timeprecision 1ns;
  task automatic send(input logic [7:0] id, input logic [7:0] d[8], input int n, input bit bad);
    int s;
    s = 0;
    frame_start_o <= 1'b1;
    frame_id_o <= id;
    @(posedge clk_i);
    frame_start_o <= 1'b0;
    for (int i = 0; i < n; i++) begin
      s = s + d[i];
      if (s > 255)
        s = s - 255;
      byte_valid_o <= 1'b1;
      byte_o <= d[i];
      @(posedge clk_i);
    end
    byte_o <= ~s[7:0] ^ {7'h00, bad};
    @(posedge clk_i);
    byte_valid_o <= 1'b0;
    byte_o <= ~byte_o;
  endtask
endmodule // lin_master_model

// [test/lin_otp_write_and_sleep_decoder_tb.sv]
// Self-checking bench for the command decoder.
module lin_otp_write_and_sleep_decoder_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 0, reset_n_i = 0, wake_i = 0, fs, bv, wr, sl, er;
  logic [7:0] id, b, dat;
  logic [3:0] ad;
  logic [5:0] na = 6'h2a;
  logic [7:0] f[8];
  int n_mismatch = 0, samples_checked = 0;
  initial forever #4 clk_i = ~clk_i;
  lin_master_model m_u (.clk_i, .frame_start_o(fs), .frame_id_o(id), .byte_valid_o(bv), .byte_o(b));
  lin_otp_write_and_sleep_decoder dut_u (.clk_i, .reset_n_i, .frame_start_i(fs), .frame_id_i(id),
    .byte_valid_i(bv), .byte_i(b), .node_addr_i(na), .wake_i, .otp_write_o(wr), .otp_addr_o(ad),
    .otp_data_o(dat), .sleep_o(sl), .frame_error_o(er));
  task chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %h vs %h", $time, got, exp);
    end
  endtask
  task frame(input logic [7:0] i, input int n, input bit bad, input logic w, input logic e);
    m_u.send(i, f, n, bad);
    @(negedge clk_i);
    chk({7'h0, wr}, {7'h0, w});
    chk({7'h0, er}, {7'h0, e});
    @(posedge clk_i);
  endtask
  task t_otp;
    f = '{8'hea, 8'hff, 8'hfc, 8'ha5, 0, 0, 0, 0};
    frame(8'he7, 4, 0, 1, 0);
    chk({4'h0, ad}, 8'h0c);
    chk(dat, 8'ha5);
    f[0] = 8'heb;
    frame(8'he7, 4, 0, 0, 1);
    f[0] = 8'hea;
    frame(8'he7, 4, 1, 0, 1);
    f[1] = 8'hfe;
    frame(8'he7, 4, 0, 0, 1);
    chk(dat, 8'ha5);
  endtask
  task t_sleep;
    f = '{8'h00, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};
    frame(8'h3c, 8, 0, 0, 0);
    chk({7'h0, sl}, 8'h01);
    wake_i <= 1;
    repeat (2) @(posedge clk_i);
    wake_i <= 0;
    @(negedge clk_i);
    chk({7'h0, sl}, 8'h00);
    @(posedge clk_i);
    f[0] = 8'hff;
    frame(8'h3c, 8, 0, 0, 1);
    chk({7'h0, sl}, 8'h00);
  endtask
  task t_misc;
    na <= 6'h15;
    f = '{8'hd5, 8'hff, 8'hf3, 8'h5c, 0, 0, 0, 0};
    frame(8'he7, 4, 0, 1, 0);
    chk({4'h0, ad}, 8'h03);
    chk(dat, 8'h5c);
    frame(8'h11, 4, 0, 0, 0);
    chk(dat, 8'h5c);
    reset_n_i <= 0;
    repeat (2) @(posedge clk_i);
    reset_n_i <= 1;
    @(negedge clk_i);
    chk({4'h0, ad}, 8'h00);
    chk(dat, 8'h00);
    @(posedge clk_i);
  endtask
  task print_verdict;
    if (n_mismatch == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    reset_n_i <= 1;
    @(posedge clk_i);
    t_otp;
    t_sleep;
    t_misc;
    print_verdict;
  end
  initial begin
    repeat (2000) @(posedge clk_i);
    n_mismatch++;
    print_verdict;
  end
endmodule // lin_otp_write_and_sleep_decoder_tb
